// *** core/rpc_consts.svh ***
// constants of the reset and power-down controller: register map, reset
// tables, status bits and timing; all offsets are byte addresses of the
// plain register port.
// Behaviour
// R1: only the stop instruction puts the device into the stop state.
// R2: stop halts the system oscillator and freezes execution at the stop.
// R3: while stopped, memory and register contents stay untouched.
// R4: entering stop keeps port pin states and directions as they were.
// R5: entering stop clears the watchdog count, which then keeps counting.
// R6: stop sets the stop-state flag and clears the watchdog time-out flag.
// R7: watchdog oscillator keeps running while the system clock is stopped.
// R8: watchdog oscillator is free running with a period of about 71 us.
// R9: a configuration option disables the watchdog oscillator entirely.
// R10: wake-up continues from preserved state without a full reset.
// R11: every reset kind loads zero into the program counter low byte.
// R12: reset flags: 00 power-on/pin, 1u running time-out, 11 stopped time-out.
// R13: ports load all ones on every reset except the warm reset.
// R14: interrupt control loads 00-0 except warm reset, which keeps it.
// R15: timer counts kept only on warm reset; timer control loads 00-0 1. The code keeps the counts on pin and running time-out resets too.
// R16: pointer, accumulator, table registers unknown at power-on, else kept.
// R17: aux control loads 0000 0x00 except on warm reset.
// R18: oscillator control cleared; warm reset clears only bit 4.
// R19: radio control cleared; warm reset clears only the upper three bits.
// R20: period timer cleared on every reset except the warm reset.
// R21: table page zero at power-on; pin-run clears 4, others 5 upper bits.
// R22: after any wake-up wait 512 system clocks before resuming.
// R23: wake status unknown on cold resets, kept on warm; unused bits read 0.
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

`define RPC_NREG 26
`define RPC_IDX_PCL 5'h00
`define RPC_IDX_STATUS 5'h05
`define RPC_IDX_PA 5'h0A
`define RPC_IDX_PE 5'h12
`define RPC_IDX_WSR 5'h14
`define RPC_IDX_AUX_CONTROL_REG 5'h15
`define RPC_IDX_OSCILLATOR_CONTROL 5'h16
`define RPC_IDX_PTR 5'h18
`define RPC_IDX_TABLE_HIGH_PAGE 5'h19

`define RPC_ST_TO 8'h20
`define RPC_ST_PDF 8'h10
`define RPC_RO_STATUS 8'h30
`define RPC_RO_WSR 8'hF8
`define RPC_RO_AUX_CONTROL_REG 8'h0C
`define RPC_WSR_FLAGS 8'hF8
`define RPC_TABLE_HIGH_PAGE_PIN_RUN_MASK 8'hF0
`define RPC_WARM_OSCILLATOR_CONTROL_MASK 8'h10

// tables hold one byte per register, index 25 leftmost, index 0 rightmost
`define RPC_PO_TAB {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, \
  8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, \
  8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}
`define RPC_COLD_TAB {8'hF8, 8'hFF, 8'hFF, 8'hFF, 8'hFB, 8'h00, 8'h0F, \
  8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, \
  8'h1B, 8'h00, 8'h00, 8'h0D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF}
`define RPC_WARM_TAB {8'hF8, 8'h00, 8'hE0, 8'h10, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF}
`define RPC_IMPL_TAB {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF8, 8'h0F, \
  8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, \
  8'h1B, 8'hFF, 8'hFF, 8'h0D, 8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF}

`define RPC_CLK_FREQ_MHZ 200
`define RPC_WDT_OSC_PERIOD_US 71
`define RPC_WDT_TICKS 8192
`define RPC_RESUME_CYCLES 512

`endif

// *** core/rpc_pkg.sv ***
// types shared by the reset and power-down controller
// assumes nothing beyond a SystemVerilog compiler
package rpc_pkg;

  typedef enum logic [1:0]
  {
    RPC_RUN = 2'b00,
    RPC_STOP = 2'b01,
    RPC_WAKE = 2'b10,
    RPC_PINHOLD = 2'b11
  } rpc_state_t;

  typedef enum logic [2:0]
  {
    RPC_RK_POWER_ON = 3'b000,
    RPC_RK_WDT_RUN = 3'b001,
    RPC_RK_PIN_RUN = 3'b010,
    RPC_RK_PIN_STOP = 3'b011,
    RPC_RK_WDT_STOP = 3'b100
  } rpc_rst_kind_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rpc_bus_req_t;

  typedef struct packed {
    logic [7:0] a_data;
    logic [7:0] a_dir;
    logic [7:0] b_data;
    logic [7:0] b_dir;
    logic [7:0] c_data;
    logic [7:0] c_dir;
    logic [7:0] d_data;
    logic [7:0] d_dir;
    logic [3:0] e_data;
    logic [3:0] e_dir;
  } rpc_ports_t;

endpackage

// *** core/rpc_sync2.sv ***
// two flip-flop synchroniser for levels arriving from pins
// assumes slow levels; a pulse shorter than one clock can be missed
`timescale 1ns/1ps

module rpc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** core/rpc_top.sv ***
// reset and power-down controller: reset kinds, stop state, watchdog,
// wake-up delay and the registers whose reset values depend on them.
// assumes the core gives one-cycle pulses on CLOCK; CLOCK itself runs
// free and stands for both the system clock and the watchdog oscillator.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "rpc_consts.svh"

module rpc_top #(
  parameter int WDT_OSC_CYCLES = `RPC_WDT_OSC_PERIOD_US * `RPC_CLK_FREQ_MHZ,
  parameter int WDT_TICKS = `RPC_WDT_TICKS
) (
  // clock and power-on reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // pins and configuration options, asynchronous
  input wire logic EXT_RESET_PIN_N,
  input wire logic WDT_ENABLE,
  // core events
  input wire logic STOP_EXEC,
  input wire logic CLR_WDT,
  input wire logic WAKE_EVENT,
  input wire logic [4:0] WAKE_FLAGS,
  // register port
  input wire rpc_pkg::rpc_bus_req_t BUS_REQ,
  output logic [7:0] RD_DATA,
  // power and reset control
  output logic SYS_OSC_RUN,
  output logic EXEC_HOLD,
  output logic CORE_RESET,
  output rpc_pkg::rpc_rst_kind_t RESET_KIND,
  // port latches
  output rpc_pkg::rpc_ports_t PORTS
);

  localparam int NREG = `RPC_NREG;
  localparam logic [NREG*8-1:0] PO_TAB = `RPC_PO_TAB;
  localparam logic [NREG*8-1:0] COLD_TAB = `RPC_COLD_TAB;
  localparam logic [NREG*8-1:0] WARM_TAB = `RPC_WARM_TAB;
  localparam logic [NREG*8-1:0] IMPL_TAB = `RPC_IMPL_TAB;
  localparam logic [15:0] DIV_LAST = 16'(WDT_OSC_CYCLES - 1);
  localparam logic [15:0] WDT_LAST = 16'(WDT_TICKS - 1);
  localparam logic [9:0] RESUME_LAST = 10'(`RPC_RESUME_CYCLES - 1);

  // next value of one register for a reset event, a write or a hw update
  function automatic logic [7:0] reg_next(
    input int idx,
    input logic [7:0] cur,
    input logic ev,
    input rpc_pkg::rpc_rst_kind_t kind,
    input logic wr,
    input logic [7:0] wd,
    input logic [7:0] hw_set,
    input logic [7:0] hw_clr
  );
    logic [7:0] cm;
    logic [7:0] ro;
    logic [7:0] nxt;
    cm = COLD_TAB[idx*8 +: 8]; // [R17] [R20]
    ro = 8'h00;
    nxt = cur;
    if (idx == int'(`RPC_IDX_TABLE_HIGH_PAGE) && kind == rpc_pkg::RPC_RK_PIN_RUN)
      cm = `RPC_TABLE_HIGH_PAGE_PIN_RUN_MASK; // [R21]
    if (idx == int'(`RPC_IDX_STATUS))
      ro = `RPC_RO_STATUS;
    if (idx == int'(`RPC_IDX_WSR))
      ro = `RPC_RO_WSR;
    if (idx == int'(`RPC_IDX_AUX_CONTROL_REG))
      ro = `RPC_RO_AUX_CONTROL_REG;
    if (ev && kind == rpc_pkg::RPC_RK_WDT_STOP)
      nxt = cur & ~WARM_TAB[idx*8 +: 8]; // [R11] [R18] [R19] [R21]
    else if (ev)
      nxt = (cur & ~cm) | (PO_TAB[idx*8 +: 8] & cm); // [R13] [R14] [R15]
    else if (wr)
      nxt = (cur & ro) | (wd & ~ro);
    // a hardware set wins over any clear in the same cycle
    nxt = (nxt & ~hw_clr) | hw_set;
    return nxt & IMPL_TAB[idx*8 +: 8]; // [R23]
  endfunction

  logic pin_low_s;
  logic wdt_en_s;
  rpc_pkg::rpc_state_t st_q;
  rpc_pkg::rpc_state_t st_d;
  rpc_pkg::rpc_rst_kind_t kind_q;
  rpc_pkg::rpc_rst_kind_t kind_d;
  logic pin_from_stop_q;
  logic pin_from_stop_d;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [15:0] wdt_cnt_q;
  logic [15:0] wdt_cnt_d;
  logic [9:0] wake_cnt_q;
  logic [9:0] wake_cnt_d;
  logic [7:0] regs_q [NREG];
  logic [7:0] regs_d [NREG];
  logic [NREG*8-1:0] regs_flat;
  logic [7:0] rd_q;
  logic osc_run_q;
  logic hold_q;
  logic core_rst_q;

  rpc_sync2 #(
    .W(2),
    .INIT(2'b01)
  ) u_pin_sync (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .async_in({~EXT_RESET_PIN_N, WDT_ENABLE}),
    .sync_out({pin_low_s, wdt_en_s})
  );

  // state decode
  wire in_run = (st_q == rpc_pkg::RPC_RUN);
  wire in_stop = (st_q == rpc_pkg::RPC_STOP);
  wire in_wake = (st_q == rpc_pkg::RPC_WAKE);
  wire in_hold = (st_q == rpc_pkg::RPC_PINHOLD);
  wire ptr_zero = (regs_q[`RPC_IDX_PTR] == 8'h00);

  // watchdog oscillator: free running divider, stopped only by the option
  wire wdt_tick = wdt_en_s && (div_q == DIV_LAST); // [R8] [R9]
  wire wdt_ovf = wdt_tick && (wdt_cnt_q == WDT_LAST);

  // events, pin reset first, then watchdog, then the stop instruction
  wire pin_ev = pin_low_s && !in_hold;
  wire wdt_run_ev = !pin_ev && in_run && wdt_ovf;
  // while stopped a time-out exists only with the period timer at zero
  wire wdt_stop_ev = !pin_ev && in_stop && wdt_ovf && ptr_zero;
  wire stop_acc = in_run && STOP_EXEC && !pin_ev && !wdt_ovf; // [R1]
  wire wake_acc = in_stop && WAKE_EVENT && !pin_ev && !wdt_stop_ev;
  wire rst_ev = pin_ev || wdt_run_ev || wdt_stop_ev;
  wire resume_done = in_wake && (wake_cnt_q == RESUME_LAST);

  assign kind_d = !rst_ev ? kind_q :
                  (pin_ev && in_run) ? rpc_pkg::RPC_RK_PIN_RUN :
                  pin_ev ? rpc_pkg::RPC_RK_PIN_STOP :
                  wdt_run_ev ? rpc_pkg::RPC_RK_WDT_RUN :
                  rpc_pkg::RPC_RK_WDT_STOP;
  assign pin_from_stop_d = pin_ev ? !in_run : pin_from_stop_q;

  // status flags: reset flags per kind, stop flag on stop, clear on CLR_WDT
  wire [7:0] st_set = stop_acc ? `RPC_ST_PDF :
                      wdt_run_ev ? `RPC_ST_TO :
                      wdt_stop_ev ? (`RPC_ST_TO | `RPC_ST_PDF) :
                      8'h00; // [R6] [R12]
  wire [7:0] st_clr = stop_acc ? `RPC_ST_TO :
                      pin_ev ? (`RPC_ST_TO | `RPC_ST_PDF) :
                      CLR_WDT ? `RPC_ST_PDF :
                      8'h00; // [R6] [R12]
  wire [7:0] wsr_set = wake_acc ? {WAKE_FLAGS, 3'b000} : 8'h00;
  wire [7:0] wsr_clr = wake_acc ? `RPC_WSR_FLAGS : 8'h00;
  // software may write only while the program runs
  wire bus_wr = BUS_REQ.wr && in_run; // [R3]
  wire addr_ok = (BUS_REQ.addr < 5'(NREG));

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      rpc_pkg::RPC_RUN:
      begin
        if (pin_ev)
          st_d = rpc_pkg::RPC_PINHOLD;
        else if (stop_acc)
          st_d = rpc_pkg::RPC_STOP; // [R1] [R2]
      end
      rpc_pkg::RPC_STOP:
      begin
        if (pin_ev)
          st_d = rpc_pkg::RPC_PINHOLD;
        else if (wdt_stop_ev || wake_acc)
          st_d = rpc_pkg::RPC_WAKE; // [R10]
      end
      rpc_pkg::RPC_WAKE:
      begin
        if (pin_ev)
          st_d = rpc_pkg::RPC_PINHOLD;
        else if (resume_done)
          st_d = rpc_pkg::RPC_RUN; // [R22]
      end
      rpc_pkg::RPC_PINHOLD:
      begin
        if (!pin_low_s)
          st_d = pin_from_stop_q ? rpc_pkg::RPC_WAKE : rpc_pkg::RPC_RUN;
      end
    endcase
  end

  // the divider never stops for the stop state, only for the option
  assign div_d = (!wdt_en_s || wdt_tick) ? 16'h0000 : div_q + 16'h0001; // [R7]
  assign wdt_cnt_d = (stop_acc || CLR_WDT || rst_ev || in_hold) ? 16'h0000 :
                     wdt_ovf ? 16'h0000 :
                     wdt_tick ? wdt_cnt_q + 16'h0001 :
                     wdt_cnt_q; // [R5]
  assign wake_cnt_d = in_wake ? wake_cnt_q + 10'h001 : 10'h000; // [R22]

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_q <= rpc_pkg::RPC_RUN;
      kind_q <= rpc_pkg::RPC_RK_POWER_ON;
      pin_from_stop_q <= 1'b0;
      div_q <= 16'h0000;
      wdt_cnt_q <= 16'h0000;
      wake_cnt_q <= 10'h000;
    end
    else
    begin
      st_q <= st_d;
      kind_q <= kind_d;
      pin_from_stop_q <= pin_from_stop_d;
      div_q <= div_d;
      wdt_cnt_q <= wdt_cnt_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  // one generate entry per register, all with the same update function
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      wire [7:0] hw_set = (gi == int'(`RPC_IDX_STATUS)) ? st_set :
                          (gi == int'(`RPC_IDX_WSR)) ? wsr_set : 8'h00;
      wire [7:0] hw_clr = (gi == int'(`RPC_IDX_STATUS)) ? st_clr :
                          (gi == int'(`RPC_IDX_WSR)) ? wsr_clr : 8'h00;
      wire wr_hit = bus_wr && (BUS_REQ.addr == 5'(gi));
      assign regs_d[gi] = reg_next(gi, regs_q[gi], rst_ev, kind_d, wr_hit,
                                   BUS_REQ.wdata, hw_set, hw_clr);
      assign regs_flat[gi*8 +: 8] = regs_q[gi];
      always_ff @(posedge CLOCK or negedge RESET_N)
      begin
        if (!RESET_N)
          regs_q[gi] <= PO_TAB[gi*8 +: 8]; // [R16]
        else
          regs_q[gi] <= regs_d[gi];
      end
    end
  endgenerate

  // outputs come from flip-flops; unmapped reads answer zero
  wire [7:0] rd_d = (BUS_REQ.rd && addr_ok) ? regs_q[BUS_REQ.addr] : 8'h00;

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rd_q <= 8'h00;
      osc_run_q <= 1'b1;
      hold_q <= 1'b0;
      core_rst_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_d;
      osc_run_q <= (st_d != rpc_pkg::RPC_STOP); // [R2]
      hold_q <= (st_d != rpc_pkg::RPC_RUN);
      core_rst_q <= rst_ev || (st_d == rpc_pkg::RPC_PINHOLD);
    end
  end

  assign RD_DATA = rd_q;
  assign SYS_OSC_RUN = osc_run_q;
  assign EXEC_HOLD = hold_q;
  assign CORE_RESET = core_rst_q;
  assign RESET_KIND = kind_q;
  // port latches drive the pins directly, so they hold through stop
  assign PORTS = {regs_q[10], regs_q[11], regs_q[12], regs_q[13],
                  regs_q[14], regs_q[15], regs_q[16], regs_q[17],
                  regs_q[18][3:0], regs_q[19][3:0]}; // [R4]

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  stop_entry_a: assert property ($rose(in_stop) |-> $past(STOP_EXEC)) // [R1]
    else $error("stop state entered without stop instruction");
  osc_halt_a: assert property (in_stop |-> !SYS_OSC_RUN && EXEC_HOLD) // [R2]
    else $error("oscillator or execution running in stop");
  regs_frozen_a: assert property (in_stop && !rst_ev && !wake_acc // [R3]
                                  |=> $stable(regs_flat))
    else $error("register changed while stopped");
  ports_hold_a: assert property ($rose(in_stop) |-> $stable(PORTS)) // [R4]
    else $error("ports changed on stop entry");
  wdt_clear_a: assert property (stop_acc |=> wdt_cnt_q == 16'h0000) // [R5]
    else $error("watchdog not cleared on stop");
  stop_flags_a: assert property (stop_acc |=> in_stop // [R6]
    && regs_q[`RPC_IDX_STATUS][5:4] == 2'b01)
    else $error("stop flags wrong after stop");
  wdt_counts_a: assert property (in_stop && wdt_tick && !wdt_ovf // [R7]
    |=> wdt_cnt_q == $past(wdt_cnt_q) + 16'h0001)
    else $error("watchdog idle while stopped");
  wdt_off_a: assert property (!wdt_en_s && !rst_ev && !stop_acc // [R9]
    && !CLR_WDT |=> $stable(wdt_cnt_q) || wdt_cnt_q == 16'h0000)
    else $error("watchdog counted while disabled");
  wake_delay_a: assert property (in_wake && st_d == rpc_pkg::RPC_RUN // [R22]
    |-> wake_cnt_q == RESUME_LAST)
    else $error("resume before wake delay");
  pcl_zero_a: assert property (rst_ev // [R11]
    |=> regs_q[`RPC_IDX_PCL] == 8'h00)
    else $error("program counter low not zero");
  warm_flags_a: assert property (wdt_stop_ev // [R12]
    |=> regs_q[`RPC_IDX_STATUS][5:4] == 2'b11 && in_wake)
    else $error("warm reset flags wrong");
  port_ones_a: assert property (rst_ev && !wdt_stop_ev // [R13]
    |=> PORTS.a_dir == 8'hFF && PORTS.e_data == 4'hF)
    else $error("ports not all ones after reset");
  warm_oscillator_control_a: assert property (wdt_stop_ev // [R18]
    |=> regs_q[`RPC_IDX_OSCILLATOR_CONTROL] ==
    ($past(regs_q[`RPC_IDX_OSCILLATOR_CONTROL]) & ~`RPC_WARM_OSCILLATOR_CONTROL_MASK))
    else $error("oscillator control wrong after warm reset");

  stop_cov: cover property (stop_acc ##1 in_stop);
  warm_cov: cover property (wdt_stop_ev);
  resume_cov: cover property (in_wake ##1 in_run);

endmodule

// *** bench/rpc_top_bench.sv ***
// self-checking bench for the reset and power-down controller
// assumes rpc_top with shortened watchdog counts; bench owns every input
`timescale 1ns/1ps
`include "rpc_consts.svh"

module rpc_top_bench;
  logic CLOCK;
  logic RESET_N;
  logic EXT_RESET_PIN_N;
  logic WDT_ENABLE;
  logic STOP_EXEC;
  logic CLR_WDT;
  logic WAKE_EVENT;
  logic [4:0] WAKE_FLAGS;
  rpc_pkg::rpc_bus_req_t BUS_REQ;
  logic [7:0] RD_DATA;
  logic SYS_OSC_RUN;
  logic EXEC_HOLD;
  logic CORE_RESET;
  rpc_pkg::rpc_rst_kind_t RESET_KIND;
  rpc_pkg::rpc_ports_t PORTS;
  localparam logic [207:0] IMPL = `RPC_IMPL_TAB;
  logic [7:0] exp_q [26];
  int n_fail = 0;
  int n_checks = 0;
  int n;

  // short watchdog so time-outs land within a few dozen clocks
  rpc_top #(.WDT_OSC_CYCLES(4), .WDT_TICKS(8)) uut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .EXT_RESET_PIN_N(EXT_RESET_PIN_N),
    .WDT_ENABLE(WDT_ENABLE), .STOP_EXEC(STOP_EXEC), .CLR_WDT(CLR_WDT),
    .WAKE_EVENT(WAKE_EVENT), .WAKE_FLAGS(WAKE_FLAGS), .BUS_REQ(BUS_REQ),
    .RD_DATA(RD_DATA), .SYS_OSC_RUN(SYS_OSC_RUN), .EXEC_HOLD(EXEC_HOLD),
    .CORE_RESET(CORE_RESET), .RESET_KIND(RESET_KIND), .PORTS(PORTS));

  initial
  begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_count(input string what, input int e, input int g);
    n_checks++;
    if (g != e)
    begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask

  function automatic logic [7:0] wmask(input int i);
    logic [7:0] ro;
    ro = (i == 5) ? 8'h30 : (i == 20) ? 8'hF8 : (i == 21) ? 8'h0C : 8'h00;
    return IMPL[8*i +: 8] & ~ro;
  endfunction

  function automatic logic pick(input int s);
    return (s == 0) ? SYS_OSC_RUN : (s == 1) ? EXEC_HOLD : CORE_RESET;
  endfunction

  // take marks whether the write should land (run state) or be dropped
  task automatic wr(input int a, input logic [7:0] d, input bit take);
    @(posedge CLOCK);
    BUS_REQ <= {1'b0, 1'b1, a[4:0], d};
    @(posedge CLOCK);
    BUS_REQ <= '0;
    if (take && a < 26)
      exp_q[a] = (d & wmask(a)) | (exp_q[a] & ~wmask(a));
  endtask

  task automatic rd(input int a, output logic [7:0] d);
    @(posedge CLOCK);
    BUS_REQ <= {1'b1, 1'b0, a[4:0], 8'h00};
    @(posedge CLOCK);
    BUS_REQ <= '0;
    #1 d = RD_DATA;
  endtask

  // 0 oscillator run, 1 execution hold, 2 core reset; bounded wait
  task automatic wait_sig(input int s, input logic v, input int lim,
                          output int cyc);
    // look just after the edge, never in the edge's own time step
    #1;
    cyc = 0;
    while (pick(s) !== v)
    begin
      @(posedge CLOCK);
      #1 cyc++;
      if (cyc > lim)
      begin
        n_fail++;
        $display("mismatch wait on %0d expected %b seen %b", s, v, pick(s));
        break;
      end
    end
  endtask

  task automatic check_all();
    logic [7:0] d;
    for (int i = 0; i <= 26; i++)
    begin
      rd(i, d);
      chk_byte($sformatf("register %0d", i), (i < 26) ? exp_q[i] : 8'h00, d);
    end
    chk_byte("port a data", exp_q[10], PORTS.a_data);
    chk_byte("port d dir", exp_q[17], PORTS.d_dir);
    chk_byte("port e dir", {4'h0, exp_q[19][3:0]}, {4'h0, PORTS.e_dir});
  endtask

  task automatic fill(input logic [7:0] base);
    for (int i = 0; i < 26; i++)
      wr(i, base ^ 8'(i * 37), 1'b1);
  endtask

  task automatic pulse_stop();
    @(posedge CLOCK);
    STOP_EXEC <= 1'b1;
    @(posedge CLOCK);
    STOP_EXEC <= 1'b0;
    wait_sig(0, 1'b0, 4, n);
    chk_byte("hold in stop", 8'h01, {7'h00, EXEC_HOLD});
    exp_q[5] = (exp_q[5] & 8'h0F) | 8'h10;
  endtask

  // cold reset kinds: power-on, pin and running time-out
  task automatic cold(input rpc_pkg::rpc_rst_kind_t k);
    exp_q[0] = 8'h00;
    if (k == rpc_pkg::RPC_RK_WDT_RUN)
      exp_q[5] = exp_q[5] | 8'h20;
    else
      exp_q[5] = exp_q[5] & 8'h0F;
    exp_q[6] = 8'h00;
    exp_q[9] = 8'h01;
    for (int i = 10; i < 18; i++)
      exp_q[i] = 8'hFF;
    exp_q[18] = 8'h0F;
    exp_q[19] = 8'h0F;
    for (int i = 21; i < 25; i++)
      exp_q[i] = 8'h00;
    exp_q[25] &= (k == rpc_pkg::RPC_RK_PIN_RUN) ? 8'h0F : 8'h07;
  endtask

  task automatic pin_reset(input rpc_pkg::rpc_rst_kind_t k);
    @(posedge CLOCK);
    EXT_RESET_PIN_N <= 1'b0;
    repeat (6) @(posedge CLOCK);
    #1 chk_byte("core reset level", 8'h01, {7'h00, CORE_RESET});
    chk_byte("pin kind", {5'h00, k}, {5'h00, RESET_KIND});
    @(posedge CLOCK);
    EXT_RESET_PIN_N <= 1'b1;
    cold(k);
    wait_sig(1, 1'b0, 700, n);
  endtask

  initial
  begin
    RESET_N = 1'b0;
    EXT_RESET_PIN_N = 1'b1;
    WDT_ENABLE = 1'b0;
    STOP_EXEC = 1'b0;
    CLR_WDT = 1'b0;
    WAKE_EVENT = 1'b0;
    WAKE_FLAGS = 5'h00;
    BUS_REQ = '0;
    foreach (exp_q[i])
      exp_q[i] = 8'h00;
    cold(rpc_pkg::RPC_RK_POWER_ON);
    exp_q[25] = 8'h00;
    repeat (10) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    check_all();
    $display("test power-on values done");

    fill(8'h5A);
    check_all();
    $display("test write and read back done");

    // wake source outside stop must not disturb the running core
    @(posedge CLOCK);
    WAKE_FLAGS <= 5'h0A;
    WAKE_EVENT <= 1'b1;
    @(posedge CLOCK);
    WAKE_EVENT <= 1'b0;
    repeat (3) @(posedge CLOCK);
    #1 chk_byte("osc after stray wake", 8'h01, {7'h00, SYS_OSC_RUN});
    pulse_stop();
    wr(24, 8'hAA, 1'b0);
    repeat (100) @(posedge CLOCK);
    #1 chk_byte("osc with watchdog off", 8'h00, {7'h00, SYS_OSC_RUN});
    check_all();
    @(posedge CLOCK);
    WAKE_FLAGS <= 5'h15;
    WAKE_EVENT <= 1'b1;
    @(posedge CLOCK);
    WAKE_EVENT <= 1'b0;
    exp_q[20] = 8'hA8;
    // count from the edge that took the wake event
    #1 chk_byte("osc on wake", 8'h01, {7'h00, SYS_OSC_RUN});
    wait_sig(1, 1'b0, 600, n);
    chk_count("resume cycles", `RPC_RESUME_CYCLES, n);
    check_all();
    @(posedge CLOCK);
    CLR_WDT <= 1'b1;
    @(posedge CLOCK);
    CLR_WDT <= 1'b0;
    exp_q[5] &= 8'hEF;
    check_all();
    $display("test stop and wake done");

    fill(8'h3C);
    @(posedge CLOCK);
    WDT_ENABLE <= 1'b1;
    wait_sig(2, 1'b1, 200, n);
    chk_byte("run timeout kind", {5'h00, rpc_pkg::RPC_RK_WDT_RUN},
             {5'h00, RESET_KIND});
    @(posedge CLOCK);
    WDT_ENABLE <= 1'b0;
    cold(rpc_pkg::RPC_RK_WDT_RUN);
    wait_sig(1, 1'b0, 10, n);
    check_all();
    $display("test running time-out done");

    fill(8'hC3);
    wr(24, 8'h00, 1'b1);
    pulse_stop();
    @(posedge CLOCK);
    WDT_ENABLE <= 1'b1;
    wait_sig(2, 1'b1, 200, n);
    chk_byte("warm kind", {5'h00, rpc_pkg::RPC_RK_WDT_STOP},
             {5'h00, RESET_KIND});
    @(posedge CLOCK);
    WDT_ENABLE <= 1'b0;
    exp_q[0] = 8'h00;
    exp_q[5] = (exp_q[5] & 8'h0F) | 8'h30;
    exp_q[22] &= 8'hEF;
    exp_q[23] &= 8'h1F;
    exp_q[25] &= 8'h07;
    wait_sig(1, 1'b0, 700, n);
    check_all();
    $display("test warm reset done");

    fill(8'h96);
    pin_reset(rpc_pkg::RPC_RK_PIN_RUN);
    check_all();
    $display("test pin reset while running done");

    fill(8'h69);
    pulse_stop();
    pin_reset(rpc_pkg::RPC_RK_PIN_STOP);
    check_all();
    $display("test pin reset while stopped done");
    conclude();
  end

  initial
  begin
    #(60000 * 5);
    n_fail++;
    $display("mismatch run length expected end seen timeout");
    conclude();
  end
endmodule
